// ===== core/phy_regs_pkg.sv
// register offsets, field positions, reset values and timing constants for
// the coding-path and error-counter register bank.
// assumes a byte-addressed register port with 16-bit data per register.
`default_nettype none

package phy_regs_pkg;

    // ------------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] FALSE_CARRIER_COUNT_OFS = 8'hd0;
    localparam logic [7:0] SYMBOL_ERROR_COUNT_OFS = 8'hd4;
    localparam logic [7:0] CODING_PATH_OFS = 8'hd8;
    localparam logic [7:0] PHY_CONTROL_OFS = 8'he4;

    // ------------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------------
    localparam int REG_W = 16;
    localparam int TALLY_W = 8;
    localparam logic [15:0] CODING_PATH_RST = 16'h0100;
    localparam logic [15:0] PHY_CONTROL_RST = 16'h003f;
    localparam logic [15:0] ZERO_WORD = 16'h0000;

    // ------------------------------------------------------------------
    // coding path register fields
    // ------------------------------------------------------------------
    localparam int BLOCK_CODE_BYPASS_BIT = 12;
    localparam int RX_CLOCK_FREE_BIT = 11;
    localparam int TRUE_QUIET_BIT = 10;
    localparam int SD_OVERRIDE_BIT = 9;
    localparam int SD_ALGORITHM_BIT = 8;
    localparam int FAST_LINK_FORCE_BIT = 5;
    localparam int NRZI_BYPASS_BIT = 2;
    localparam logic [15:0] CODING_PATH_WMASK = 16'h1f24;

    // ------------------------------------------------------------------
    // phy control register fields
    // ------------------------------------------------------------------
    localparam int LONG_LFSR_BIT = 11;
    localparam int SELF_TEST_RESULT_BIT = 10;
    localparam int SELF_TEST_RUN_BIT = 9;
    localparam int LED_STRETCH_BYPASS_BIT = 8;
    localparam int PAUSE_BOTH_BIT = 7;
    localparam int SPARE_HI_BIT = 6;
    localparam int SPARE_LO_BIT = 5;
    localparam int ADDR_HI_BIT = 4;
    localparam int ADDR_LO_BIT = 0;

    // ------------------------------------------------------------------
    // self-test pattern generators: taps of the two sequences
    // ------------------------------------------------------------------
    localparam int LONG_LFSR_LEN = 15;
    localparam int LONG_TAP_A = 14;
    localparam int LONG_TAP_B = 13;
    localparam int SHORT_TAP_A = 8;
    localparam int SHORT_TAP_B = 4;
    localparam logic [14:0] LFSR_SEED = 15'h7fff;
    localparam logic [3:0] SYNC_BITS = 4'h f;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLOCK_MHZ = 50;
    localparam int LED_STRETCH_MS = 50;
    localparam int LED_STRETCH_CYCLES = LED_STRETCH_MS * 1000 * CLOCK_MHZ;

endpackage : phy_regs_pkg

`default_nettype wire

// ===== core/sat_event_counter.sv
// saturating event tally with clear-on-read, software load and a
// half-range event pulse.
// assumes inc_in, read_clr_in and load_in come from the same clock domain.
`default_nettype none

module sat_event_counter #(
    parameter int WIDTH = 8
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic clk_en_in,
    input wire logic inc_in,
    input wire logic read_clr_in,
    input wire logic load_in,
    input wire logic [WIDTH-1:0] load_value_in,
    output logic [WIDTH-1:0] count_out,
    output logic half_full_out
);

    // ------------------------------------------------------------------
    // next-value selection
    // ------------------------------------------------------------------
    localparam logic [WIDTH-1:0] ALL_ONES = {WIDTH{1'b1}};
    localparam logic [WIDTH-1:0] HALF = {1'b1, {(WIDTH-1){1'b0}}};
    localparam logic [WIDTH-1:0] ONE = {{(WIDTH-1){1'b0}}, 1'b1};

    // saturating increment shared by all load paths
    function automatic logic [WIDTH-1:0] bump(input logic [WIDTH-1:0] v);
        bump = (v == ALL_ONES) ? ALL_ONES : v + ONE;
    endfunction : bump

    logic [WIDTH-1:0] count_q;
    logic [WIDTH-1:0] count_d;
    logic half_q;
    wire logic [WIDTH-1:0] base = load_in ? load_value_in :
        (read_clr_in ? '0 : count_q);
    // an event in the clearing cycle is kept: it counts from the new base
    assign count_d = inc_in ? bump(base) : base;

    // half-range pulse on the cycle the tally first reaches half
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            count_q <= '0;
            half_q <= 1'b0;
        end
        else if (clk_en_in)
        begin
            count_q <= count_d;
            half_q <= (count_d == HALF) && (count_q != HALF);
        end
    end

    assign count_out = count_q;
    assign half_full_out = half_q;

endmodule : sat_event_counter

`default_nettype wire

// ===== core/phy_pcs_regs.sv
// register bank for the fast ethernet coding path: two error tallies,
// coding configuration, phy control, self test and activity led stretch.
// assumes event inputs are on clock_in; line_signal_detect_in and
// self_test_rx_in arrive from the analog side and are synchronised here.
`default_nettype none

module phy_pcs_regs #(
    parameter int STRETCH_CYCLES = phy_regs_pkg::LED_STRETCH_CYCLES
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic clk_en_in,
    // register port
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [15:0] reg_wdata_in,
    output logic [15:0] reg_rdata_out,
    output logic reg_rvalid_out,
    // receive path events
    input wire logic false_carrier_in,
    input wire logic carrier_valid_in,
    input wire logic invalid_symbol_in,
    input wire logic collision_in,
    // link status sources
    input wire logic mac_fast_link_force_in,
    input wire logic local_pause_in,
    input wire logic partner_pause_in,
    input wire logic line_signal_detect_in,
    input wire logic link_status_in,
    input wire logic activity_in,
    // self-test loop
    input wire logic self_test_rx_in,
    output logic self_test_tx_out,
    // coding path controls, port address, led outputs and tally half-full pulses
    output logic block_code_bypass_out,
    output logic recovered_rx_clock_free_out,
    output logic true_quiet_enable_out,
    output logic signal_detect_out,
    output logic signal_detect_algorithm_sel_out,
    output logic fast_link_force_out,
    output logic nrzi_bypass_out,
    output logic [4:0] port_mgmt_address_out,
    output logic link_led_out,
    output logic activity_led_out,
    output logic false_carrier_half_full_out,
    output logic symbol_error_half_full_out
);

    // ------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------
    wire logic sel_fc = reg_addr_in == phy_regs_pkg::FALSE_CARRIER_COUNT_OFS;
    wire logic sel_se = reg_addr_in == phy_regs_pkg::SYMBOL_ERROR_COUNT_OFS;
    wire logic sel_cp = reg_addr_in == phy_regs_pkg::CODING_PATH_OFS;
    wire logic sel_pc = reg_addr_in == phy_regs_pkg::PHY_CONTROL_OFS;
    wire logic wr_fc = reg_wr_in && sel_fc;
    wire logic wr_se = reg_wr_in && sel_se;
    wire logic wr_cp = reg_wr_in && sel_cp;
    wire logic wr_pc = reg_wr_in && sel_pc;
    wire logic rd_fc = reg_rd_in && sel_fc;
    wire logic rd_se = reg_rd_in && sel_se;

    // ------------------------------------------------------------------
    // synchronisers for the analog-side inputs
    // ------------------------------------------------------------------
    logic [1:0] sd_sync_q;
    logic [1:0] st_rx_sync_q;

    // two stages each; only stage one feeds stage two
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            sd_sync_q <= 2'b00;
            st_rx_sync_q <= 2'b00;
        end
        else if (clk_en_in)
        begin
            sd_sync_q <= {sd_sync_q[0], line_signal_detect_in};
            st_rx_sync_q <= {st_rx_sync_q[0], self_test_rx_in};
        end
    end

    wire logic line_sd = sd_sync_q[1];
    wire logic st_rx_bit = st_rx_sync_q[1];

    // ------------------------------------------------------------------
    // false carrier tally
    // ------------------------------------------------------------------
    logic [7:0] fc_tally;
    logic fc_half;

    sat_event_counter #(
        .WIDTH(phy_regs_pkg::TALLY_W)
    ) false_carrier_tally (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .clk_en_in(clk_en_in),
        .inc_in(false_carrier_in),
        .read_clr_in(rd_fc),
        .load_in(wr_fc),
        .load_value_in(reg_wdata_in[7:0]),
        .count_out(fc_tally),
        .half_full_out(fc_half)
    );

    // ------------------------------------------------------------------
    // symbol error qualification: one count per carrier event with a bad symbol and no collision
    // ------------------------------------------------------------------
    logic carrier_q;
    logic seen_err_q;
    logic seen_col_q;
    // flags include the current cycle so a last-cycle error still counts
    wire logic err_now = seen_err_q || (carrier_valid_in && invalid_symbol_in);
    wire logic col_now = seen_col_q || (carrier_valid_in && collision_in);
    wire logic carrier_end = carrier_q && !carrier_valid_in;
    wire logic se_inc = carrier_end && seen_err_q && !seen_col_q;

    // flags are gathered while carrier is up and dropped at its end
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            carrier_q <= 1'b0;
            seen_err_q <= 1'b0;
            seen_col_q <= 1'b0;
        end
        else if (clk_en_in)
        begin
            carrier_q <= carrier_valid_in;
            seen_err_q <= carrier_valid_in && err_now;
            seen_col_q <= carrier_valid_in && col_now;
        end
    end

    logic [7:0] se_tally;
    logic se_half;

    sat_event_counter #(
        .WIDTH(phy_regs_pkg::TALLY_W)
    ) symbol_error_tally (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .clk_en_in(clk_en_in),
        .inc_in(se_inc),
        .read_clr_in(rd_se),
        .load_in(wr_se),
        .load_value_in(reg_wdata_in[7:0]),
        .count_out(se_tally),
        .half_full_out(se_half)
    );

    // ------------------------------------------------------------------
    // coding path register
    // ------------------------------------------------------------------
    logic [15:0] coding_path_q;

    // reserved bits are masked off so they read as zero
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
            coding_path_q <= phy_regs_pkg::CODING_PATH_RST;
        else if (clk_en_in && wr_cp)
            coding_path_q <= reg_wdata_in & phy_regs_pkg::CODING_PATH_WMASK;
    end

    // ------------------------------------------------------------------
    // phy control register
    // ------------------------------------------------------------------
    logic long_lfsr_select_q;
    logic self_test_run_q;
    logic led_stretch_bypass_q;
    logic [1:0] spare_q;
    logic [4:0] port_addr_q;
    logic pause_both_q;

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            long_lfsr_select_q <=
                phy_regs_pkg::PHY_CONTROL_RST[phy_regs_pkg::LONG_LFSR_BIT];
            self_test_run_q <=
                phy_regs_pkg::PHY_CONTROL_RST[phy_regs_pkg::SELF_TEST_RUN_BIT];
            led_stretch_bypass_q <= phy_regs_pkg::PHY_CONTROL_RST[
                phy_regs_pkg::LED_STRETCH_BYPASS_BIT];
            spare_q <= phy_regs_pkg::PHY_CONTROL_RST[
                phy_regs_pkg::SPARE_HI_BIT:phy_regs_pkg::SPARE_LO_BIT];
            port_addr_q <= phy_regs_pkg::PHY_CONTROL_RST[
                phy_regs_pkg::ADDR_HI_BIT:phy_regs_pkg::ADDR_LO_BIT];
        end
        else if (clk_en_in && wr_pc)
        begin
            long_lfsr_select_q <= reg_wdata_in[phy_regs_pkg::LONG_LFSR_BIT];
            self_test_run_q <= reg_wdata_in[phy_regs_pkg::SELF_TEST_RUN_BIT];
            led_stretch_bypass_q <=
                reg_wdata_in[phy_regs_pkg::LED_STRETCH_BYPASS_BIT];
            spare_q <= reg_wdata_in[
                phy_regs_pkg::SPARE_HI_BIT:phy_regs_pkg::SPARE_LO_BIT];
            port_addr_q <= reg_wdata_in[
                phy_regs_pkg::ADDR_HI_BIT:phy_regs_pkg::ADDR_LO_BIT];
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (rst_in)
            pause_both_q <= 1'b0;
        else if (clk_en_in)
            pause_both_q <= local_pause_in && partner_pause_in;
    end

    // ------------------------------------------------------------------
    // self test: pattern generator and self-synchronising checker
    // ------------------------------------------------------------------
    // feedback of either sequence from a history word
    function automatic logic lfsr_fb(input logic [14:0] h, input logic lng);
        lfsr_fb = lng ?
            (h[phy_regs_pkg::LONG_TAP_A] ^ h[phy_regs_pkg::LONG_TAP_B]) :
            (h[phy_regs_pkg::SHORT_TAP_A] ^ h[phy_regs_pkg::SHORT_TAP_B]);
    endfunction : lfsr_fb

    logic [14:0] gen_q;
    logic [14:0] chk_q;
    logic [3:0] sync_cnt_q;
    logic st_fail_q;
    logic st_pass_q;
    logic st_tx_q;
    wire logic chk_ready = sync_cnt_q == phy_regs_pkg::SYNC_BITS;
    wire logic predicted = lfsr_fb(chk_q, long_lfsr_select_q);
    wire logic mismatch = chk_ready && (predicted != st_rx_bit);
    // an all-zero history predicts zeros, so idle line never counts as sync
    wire logic bit_ok = (predicted == st_rx_bit) && (chk_q != '0);

    // runs until run bit cleared; a control write restarts it
    always_ff @(posedge clock_in)
    begin
        if (rst_in || (clk_en_in && (!self_test_run_q || wr_pc)))
        begin
            gen_q <= phy_regs_pkg::LFSR_SEED;
            chk_q <= '0;
            sync_cnt_q <= '0;
            st_tx_q <= 1'b0;
        end
        else if (clk_en_in)
        begin
            gen_q <= {gen_q[13:0], lfsr_fb(gen_q, long_lfsr_select_q)};
            st_tx_q <= gen_q[phy_regs_pkg::LONG_LFSR_LEN-1];
            chk_q <= {chk_q[13:0], st_rx_bit};
            // sync wants unbroken good predictions, so stale loop bits
            // and the seed head can never be judged as a failure
            if (!chk_ready)
                sync_cnt_q <= bit_ok ? sync_cnt_q + 4'h1 : '0;
        end
    end

    // fail latches high until the phy control register is written
    always_ff @(posedge clock_in)
    begin
        if (rst_in || (clk_en_in && wr_pc))
        begin
            st_fail_q <= 1'b0;
            st_pass_q <= 1'b0;
        end
        else if (clk_en_in && self_test_run_q)
        begin
            if (mismatch)
                st_fail_q <= 1'b1;
            if (chk_ready)
                st_pass_q <= 1'b1;
        end
    end

    wire logic st_result = st_pass_q && !st_fail_q;

    // ------------------------------------------------------------------
    // activity led stretch
    // ------------------------------------------------------------------
    localparam int STRETCH_W = $clog2(STRETCH_CYCLES + 1);
    localparam logic [STRETCH_W-1:0] STRETCH_LOAD = STRETCH_W'(STRETCH_CYCLES);
    logic [STRETCH_W-1:0] stretch_q;

    // short activity blips stay visible for the whole stretch time
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
            stretch_q <= '0;
        else if (clk_en_in)
        begin
            if (activity_in)
                stretch_q <= STRETCH_LOAD;
            else if (stretch_q != '0)
                stretch_q <= stretch_q - STRETCH_W'(1);
        end
    end

    wire logic act_led_d = led_stretch_bypass_q ? activity_in :
        (activity_in || stretch_q != '0);

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------
    wire logic [15:0] phy_control_word = {4'h0, long_lfsr_select_q,
        st_result, self_test_run_q, led_stretch_bypass_q, pause_both_q,
        spare_q, port_addr_q};
    wire logic [15:0] rdata_d =
        sel_fc ? {8'h00, fc_tally} :
        sel_se ? {8'h00, se_tally} :
        sel_cp ? coding_path_q :
        sel_pc ? phy_control_word : phy_regs_pkg::ZERO_WORD;

    // read data held until the next read; unmapped offsets return zero
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            reg_rdata_out <= phy_regs_pkg::ZERO_WORD;
            reg_rvalid_out <= 1'b0;
        end
        else if (clk_en_in)
        begin
            reg_rvalid_out <= reg_rd_in;
            if (reg_rd_in)
                reg_rdata_out <= rdata_d;
        end
    end

    // ------------------------------------------------------------------
    // registered control outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clock_in)
    begin
        if (rst_in)
        begin
            block_code_bypass_out <= 1'b0;
            recovered_rx_clock_free_out <= 1'b0;
            true_quiet_enable_out <= 1'b0;
            signal_detect_out <= 1'b0;
            signal_detect_algorithm_sel_out <= 1'b0;
            fast_link_force_out <= 1'b0;
            nrzi_bypass_out <= 1'b0;
            port_mgmt_address_out <= '0;
            link_led_out <= 1'b0;
            activity_led_out <= 1'b0;
            self_test_tx_out <= 1'b0;
            false_carrier_half_full_out <= 1'b0;
            symbol_error_half_full_out <= 1'b0;
        end
        else if (clk_en_in)
        begin
            block_code_bypass_out <=
                coding_path_q[phy_regs_pkg::BLOCK_CODE_BYPASS_BIT];
            recovered_rx_clock_free_out <=
                coding_path_q[phy_regs_pkg::RX_CLOCK_FREE_BIT];
            true_quiet_enable_out <=
                coding_path_q[phy_regs_pkg::TRUE_QUIET_BIT];
            signal_detect_out <=
                coding_path_q[phy_regs_pkg::SD_OVERRIDE_BIT] || line_sd;
            signal_detect_algorithm_sel_out <=
                coding_path_q[phy_regs_pkg::SD_ALGORITHM_BIT];
            fast_link_force_out <=
                coding_path_q[phy_regs_pkg::FAST_LINK_FORCE_BIT] ||
                mac_fast_link_force_in;
            nrzi_bypass_out <= coding_path_q[phy_regs_pkg::NRZI_BYPASS_BIT];
            port_mgmt_address_out <= port_addr_q;
            link_led_out <= link_status_in;
            activity_led_out <= act_led_d;
            self_test_tx_out <= st_tx_q;
            false_carrier_half_full_out <= fc_half;
            symbol_error_half_full_out <= se_half;
        end
    end

endmodule : phy_pcs_regs

`default_nettype wire

// ===== tb/phy_pcs_regs_properties.sv
// checker for the coding-path register bank, bound onto its top module
// assumes clk_en_in stays high while the bench runs register traffic
`default_nettype none
module phy_pcs_regs_checker (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic clk_en_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic [15:0] reg_rdata_out,
    input wire logic false_carrier_in,
    input wire logic mac_fast_link_force_in,
    input wire logic block_code_bypass_out,
    input wire logic recovered_rx_clock_free_out,
    input wire logic true_quiet_enable_out,
    input wire logic signal_detect_out,
    input wire logic signal_detect_algorithm_sel_out,
    input wire logic fast_link_force_out,
    input wire logic nrzi_bypass_out,
    input wire logic [4:0] port_mgmt_address_out,
    input wire logic false_carrier_half_full_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // ---------------------------------------------
    // decodes shared by the properties
    // ---------------------------------------------
    wire logic quiet = clk_en_in && !reg_rd_in && !reg_wr_in;
    wire logic rd_fc = clk_en_in && reg_rd_in && !reg_wr_in &&
        reg_addr_in == 8'hd0;
    wire logic wr_fc = clk_en_in && reg_wr_in && !reg_rd_in &&
        reg_addr_in == 8'hd0;
    wire logic wr_cp = clk_en_in && reg_wr_in && reg_addr_in == 8'hd8;
    wire logic wr_pc = clk_en_in && reg_wr_in && reg_addr_in == 8'he4;
    wire logic [4:0] cp_bits = {reg_wdata_in[12:10], reg_wdata_in[8],
        reg_wdata_in[2]};
    wire logic [4:0] cp_outs = {block_code_bypass_out,
        recovered_rx_clock_free_out, true_quiet_enable_out,
        signal_detect_algorithm_sel_out, nrzi_bypass_out};
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);
    // ---------------------------------------------
    // properties
    // ---------------------------------------------
    fc_count_a: assert property (wr_fc && reg_wdata_in[7:0] == 8'h7f
        ##1 quiet && !false_carrier_in ##1 quiet && false_carrier_in
        ##1 quiet && !false_carrier_in ##1 rd_fc |=> reg_rdata_out == 16'h0080)
        else $error("false carrier tally did not advance");
    fc_stick_a: assert property (wr_fc && reg_wdata_in[7:0] == 8'hff
        ##1 quiet && !false_carrier_in ##1 quiet && false_carrier_in
        ##1 quiet && !false_carrier_in ##1 rd_fc |=> reg_rdata_out == 16'h00ff)
        else $error("false carrier tally wrapped");
    read_clear_a: assert property (rd_fc && !false_carrier_in
        ##1 quiet && !false_carrier_in ##1 rd_fc |=> reg_rdata_out == 16'h0000)
        else $error("tally not cleared by read");
    upper_zero_a: assert property (clk_en_in && reg_rd_in
        && reg_addr_in[7:3] == 5'h1a |=> reg_rdata_out[15:8] == 8'h00)
        else $error("tally upper byte not zero");
    coding_copy_a: assert property (wr_cp
        ##1 clk_en_in |=> cp_outs == $past(cp_bits, 2))
        else $error("coding outputs wrong");
    sd_force_a: assert property (wr_cp && reg_wdata_in[9] ##1 clk_en_in
        |=> signal_detect_out) else $error("signal detect not forced");
    fast_force_a: assert property (clk_en_in && mac_fast_link_force_in
        |=> fast_link_force_out) else $error("fast link force not ored");
    addr_follow_a: assert property (wr_pc ##1 clk_en_in
        |=> port_mgmt_address_out == $past(reg_wdata_in[4:0], 2))
        else $error("port address not updated");
    half_full_a: assert property (wr_fc && reg_wdata_in[7:0] == 8'h7f
        ##1 quiet ##1 quiet && false_carrier_in
        |-> ##[1:4] false_carrier_half_full_out)
        else $error("half full pulse missing");
    cover property (rd_fc);
    cover property (false_carrier_half_full_out);
    cover property (wr_pc && reg_wdata_in[9]);
endmodule : phy_pcs_regs_checker
`default_nettype wire

// ===== tb/phy_pcs_regs_tb.sv
// self-checking bench for phy_pcs_regs: registers, tallies, self test
// assumes the checker module is compiled before this file
`default_nettype none
module phy_pcs_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_in = 0, rst_in = 1, reg_wr_in = 0, reg_rd_in = 0, loop_on = 0;
    logic [7:0] reg_addr_in = 8'h00, n;
    logic [15:0] reg_wdata_in = 16'h0000, reg_rdata_out, exp_q[$];
    logic false_carrier_in = 0, carrier_valid_in = 0, invalid_symbol_in = 0;
    logic collision_in = 0, mac_fast_link_force_in = 0, local_pause_in = 0;
    logic partner_pause_in = 0, activity_in = 0, self_test_rx_in = 0;
    logic reg_rvalid_out, self_test_tx_out;
    logic [31:0] seed = 32'h0000_43f2;
    int error_cnt = 0, compares = 0, cycles = 0;
    // led stretch shortened so the run stays brief
    phy_pcs_regs #(.STRETCH_CYCLES(8)) DUT (.*, .clk_en_in(1'b1),
        .line_signal_detect_in(seed[4]), .link_status_in(seed[5]),
        .block_code_bypass_out(), .recovered_rx_clock_free_out(),
        .true_quiet_enable_out(), .signal_detect_out(),
        .signal_detect_algorithm_sel_out(), .fast_link_force_out(),
        .nrzi_bypass_out(), .port_mgmt_address_out(), .link_led_out(),
        .activity_led_out(), .false_carrier_half_full_out(),
        .symbol_error_half_full_out());
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    task automatic conclude;
        if (error_cnt == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : conclude
    // ---------------------------------------------
    // register port and line event drivers
    // ---------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clock_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge clock_in);
        reg_wr_in <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clock_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        exp_q.push_back(e);
        @(posedge clock_in);
        reg_rd_in <= 1'b0;
    endtask : rd
    task automatic fc(input int k);
        repeat (k)
        begin
            @(posedge clock_in);
            false_carrier_in <= 1'b1;
            @(posedge clock_in);
            false_carrier_in <= 1'b0;
        end
    endtask : fc
    // four-cycle carrier with bad symbols leading and optional collision
    task automatic carrier(input int bad, input logic col);
        @(posedge clock_in);
        carrier_valid_in <= 1'b1;
        collision_in <= col;
        for (int i = 0; i < 4; i++)
        begin
            invalid_symbol_in <= (i < bad);
            @(posedge clock_in);
        end
        carrier_valid_in <= 1'b0;
        invalid_symbol_in <= 1'b0;
        collision_in <= 1'b0;
        @(posedge clock_in);
    endtask : carrier
    initial
    begin
        forever #10 clock_in = ~clock_in;
    end
    // random force and loop data; a broken loop feeds noise to the checker
    always @(posedge clock_in)
    begin
        seed <= xs(seed);
        mac_fast_link_force_in <= seed[1];
        activity_in <= seed[2];
        self_test_rx_in <= loop_on ? self_test_tx_out : seed[3];
        cycles++;
        if (cycles == 60000)
        begin
            error_cnt++;
            $display("Error %0t: timeout", $time);
            conclude();
        end
    end
    // read answers are matched oldest first against the noted values
    always @(posedge clock_in)
    begin
        if (reg_rvalid_out === 1'b1)
        begin
            compares++;
            if (exp_q.size() == 0 || reg_rdata_out !== exp_q[0])
            begin
                error_cnt++;
                $display("Error %0t: read %h", $time, reg_rdata_out);
            end
            if (exp_q.size() > 0)
                void'(exp_q.pop_front());
        end
    end
    initial
    begin
        repeat (10) @(posedge clock_in);
        rst_in <= 1'b0;
        rd(8'hd0, 16'h0000);
        rd(8'hd4, 16'h0000);
        rd(8'hd8, 16'h0100);
        rd(8'he4, 16'h003f);
        rd(8'h10, 16'h0000);
        wr(8'hd0, 16'hffff);
        rd(8'hd0, 16'h00ff);
        rd(8'hd0, 16'h0000);
        n = {4'h0, seed[3:0]} + 8'h01;
        fc(n);
        rd(8'hd0, {8'h00, n});
        wr(8'hd0, 16'h007f);
        fc(1);
        rd(8'hd0, 16'h0080);
        wr(8'hd0, 16'h00ff);
        fc(1);
        rd(8'hd0, 16'h00ff);
        carrier(3, 1'b0);
        carrier(2, 1'b1);
        carrier(0, 1'b0);
        rd(8'hd4, 16'h0001);
        wr(8'hd4, 16'h00fe);
        carrier(1, 1'b0);
        carrier(4, 1'b0);
        rd(8'hd4, 16'h00ff);
        wr(8'hd8, 16'hffff);
        rd(8'hd8, 16'h1f24);
        local_pause_in <= 1'b1;
        partner_pause_in <= 1'b1;
        repeat (3) @(posedge clock_in);
        rd(8'he4, 16'h00bf);
        partner_pause_in <= 1'b0;
        repeat (3) @(posedge clock_in);
        rd(8'he4, 16'h003f);
        // self test both lengths, then a broken loop
        loop_on <= 1'b1;
        wr(8'he4, 16'h0a1f);
        // software lets the test run past 1 ms before judging it
        repeat (50000) @(posedge clock_in);
        rd(8'he4, 16'h0e1f);
        wr(8'he4, 16'h021f);
        repeat (100) @(posedge clock_in);
        rd(8'he4, 16'h061f);
        loop_on <= 1'b0;
        repeat (40) @(posedge clock_in);
        loop_on <= 1'b1;
        repeat (40) @(posedge clock_in);
        rd(8'he4, 16'h021f);
        wr(8'he4, 16'h0005);
        rd(8'he4, 16'h0005);
        repeat (4) @(posedge clock_in);
        conclude();
    end
endmodule : phy_pcs_regs_tb
bind phy_pcs_regs phy_pcs_regs_checker u_props (.*);
`default_nettype wire
